// ### rtl/adc_mon_pkg.sv
// Package with constants, register map and types for the low speed adc and battery monitor.
package adc_mon_pkg;

   // ---------------------------------------------------------------
   // Converter structure
   // ---------------------------------------------------------------
   localparam int NUM_CH = 8;
   localparam int NUM_EXT = 6;
   localparam int RES_W = 10;
   localparam logic [2:0] CH_SUPPLY = 3'h6;
   localparam logic [2:0] CH_GROUND = 3'h7;

   // ---------------------------------------------------------------
   // Timing: 1.6 kHz per channel at 1.28 MHz converter clock
   // ---------------------------------------------------------------
   localparam int REF_CLK_KHZ = 1280;
   localparam int CH_RATE_HZ = 1600;
   localparam int CLK_HZ = 125000000;
   // Clocks per full sweep at the reference rate, i.e. per channel slot times eight.
   localparam int SWEEP_REF_CLKS = (REF_CLK_KHZ * 1000) / CH_RATE_HZ;
   localparam int SLOT_REF_CLKS = SWEEP_REF_CLKS / NUM_CH;
   localparam logic [15:0] SLOT_REF_CLKS_16 = 16'(SLOT_REF_CLKS);

   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_PADSEL = 8'h04;
   localparam logic [7:0] OFF_MODE = 8'h08;
   localparam logic [7:0] OFF_BATT_THR = 8'h0c;
   localparam logic [7:0] OFF_BATT_CNT = 8'h10;
   localparam logic [7:0] OFF_STATUS = 8'h14;
   localparam logic [7:0] OFF_ID = 8'h18;
   localparam logic [7:0] OFF_RESULT0 = 8'h20;
   localparam logic [7:0] OFF_LIMIT0 = 8'h40;

   // ---------------------------------------------------------------
   // Reset values and identity
   // ---------------------------------------------------------------
   localparam logic [31:0] ID_VALUE = 32'h0000_5a17;   // Arbitrary value.
   localparam logic [9:0] BATT_THR_RST = 10'h000;
   localparam logic [5:0] PADSEL_RST = 6'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CONV = 2'b01,
      ST_STORE = 2'b10
   } conv_state_t;

endpackage : adc_mon_pkg

// ### rtl/low_speed_adc.sv
// Low speed adc sequencer, range limiting, battery monitor and AXI4-Lite register slave.
//
// Summary of operation
// - The converter selects one of eight inputs, six external pads plus supply and ground.
// - Channels are sampled in turn, each at 1.6 kHz for a 1.28 MHz converter clock, scaling with it.
// - Each result is a 10-bit two's-complement value.
// - One of eight modes per channel clamps the result between a set minimum and maximum.
// - Each of the six external pads is assigned either to the converter or its other function.
// - The battery counter increments, holding at 16'hffff, whenever the supply reading falls below the threshold.
// - The battery monitor takes its readings from the internal supply channel.
// - The battery counter is readable by the dsp_processor_core.
// - All converter timing derives from the converter clock, not the system clock.
//
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
module low_speed_adc (
   input wire logic i_clk,
   input wire logic i_rst,
   // AXI4-Lite slave
   input wire logic [7:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [7:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   // Analog front end
   output logic [2:0] o_mux_sel,
   output logic o_conv_start,
   input wire logic i_conv_done,
   input wire logic [adc_mon_pkg::RES_W-1:0] i_conv_data,
   output logic [adc_mon_pkg::NUM_EXT-1:0] o_pad_adc_sel
);
   import adc_mon_pkg::*;

   // ---------------------------------------------------------------
   // Configuration registers
   // ---------------------------------------------------------------
   logic enable_r;
   logic [15:0] slot_div_r;
   logic [5:0] padsel_r;
   logic [23:0] mode_r;
   logic [9:0] batt_thr_r;
   logic [15:0] batt_cnt_r;
   logic [19:0] limit_r [0:NUM_CH-1];
   logic [9:0] result_r [0:NUM_CH-1];
   logic sample_err_r;

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   conv_state_t state_r;
   logic [15:0] tick_r;
   logic [2:0] ch_r;
   logic [9:0] sample_r;

   // The slot divider runs on i_clk, which is the converter clock itself, so the
   // per-channel rate tracks that clock in proportion.
   wire tick_due = (tick_r == 16'h0000);
   wire [15:0] tick_nxt = tick_due ? (slot_div_r - 16'h0001) : (tick_r - 16'h0001);

   // Mode decode: eight modes per channel select one of eight limit pairs.
   function automatic logic [2:0] mode_of(input logic [23:0] m, input logic [2:0] ch);
      mode_of = m[ch*3 +: 3];
   endfunction : mode_of

   wire [2:0] cur_mode = mode_of(mode_r, ch_r);
   wire signed [9:0] lim_min = limit_r[cur_mode][9:0];
   wire signed [9:0] lim_max = limit_r[cur_mode][19:10];
   wire signed [9:0] raw_s = i_conv_data;
   wire signed [9:0] clamped = (raw_s < lim_min) ? lim_min :
                               (raw_s > lim_max) ? lim_max : raw_s;
   wire supply_low = (ch_r == CH_SUPPLY) && ($signed(clamped) < $signed(batt_thr_r));

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state_r <= ST_IDLE;
         tick_r <= 16'h0000;
         ch_r <= 3'h0;
         sample_r <= 10'h000;
      end else begin
         tick_r <= enable_r ? tick_nxt : 16'h0000;
         unique case (state_r)
            ST_IDLE: begin
               if (enable_r && tick_due) begin
                  state_r <= ST_CONV;
               end
            end
            ST_CONV: begin
               if (i_conv_done) begin
                  sample_r <= clamped;
                  state_r <= ST_STORE;
               end
            end
            ST_STORE: begin
               ch_r <= ch_r + 3'h1;
               state_r <= ST_IDLE;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   assign o_mux_sel = ch_r;
   assign o_conv_start = (state_r == ST_IDLE) && enable_r && tick_due;
   assign o_pad_adc_sel = padsel_r;

   // ---------------------------------------------------------------
   // Result store and battery counter
   // ---------------------------------------------------------------
   wire store_now = (state_r == ST_STORE);
   wire batt_hit = (state_r == ST_CONV) && i_conv_done && supply_low;

   generate
      for (genvar g = 0; g < NUM_CH; g++) begin : g_res
         always_ff @(posedge i_clk) begin
            if (i_rst) begin
               result_r[g] <= 10'h000;
            end else if (store_now && ch_r == 3'(g)) begin
               result_r[g] <= sample_r;
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // AXI4-Lite write path
   // ---------------------------------------------------------------
   logic aw_held_r;
   logic w_held_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;

   assign o_awready = !aw_held_r && !o_bvalid;
   assign o_wready = !w_held_r && !o_bvalid;
   wire aw_take = i_awvalid && o_awready;
   wire w_take = i_wvalid && o_wready;
   wire aw_have = aw_held_r || aw_take;
   wire w_have = w_held_r || w_take;
   wire wr_fire = aw_have && w_have;
   wire [7:0] wa = aw_held_r ? awaddr_r : i_awaddr;
   wire [31:0] wd = w_held_r ? wdata_r : i_wdata;
   wire [3:0] ws = w_held_r ? wstrb_r : i_wstrb;
   wire [31:0] wmask = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
   wire wa_limit = (wa >= OFF_LIMIT0) && (wa < OFF_LIMIT0 + 8'h20) && (wa[1:0] == 2'h0);
   wire wa_ok = (wa == OFF_CTRL) || (wa == OFF_PADSEL) || (wa == OFF_MODE) ||
                (wa == OFF_BATT_THR) || (wa == OFF_BATT_CNT) || wa_limit;
   wire [2:0] wa_idx = wa[4:2];

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [31:0] m);
      merge = (old & ~m) | (nw & m);
   endfunction : merge

   wire [31:0] ctrl_old = {15'h0000, slot_div_r, enable_r};
   wire [31:0] ctrl_new = merge(ctrl_old, wd, wmask);
   wire [31:0] pad_new = merge({26'h0, padsel_r}, wd, wmask);
   wire [31:0] mode_new = merge({8'h00, mode_r}, wd, wmask);
   wire [31:0] thr_new = merge({22'h0, batt_thr_r}, wd, wmask);
   wire [31:0] lim_new = merge({12'h000, limit_r[wa_idx]}, wd, wmask);
   wire cnt_clear = wr_fire && (wa == OFF_BATT_CNT);

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         o_bvalid <= 1'b0;
         o_bresp <= RESP_OKAY;
      end else begin
         if (aw_take) awaddr_r <= i_awaddr;
         if (w_take) begin
            wdata_r <= i_wdata;
            wstrb_r <= i_wstrb;
         end
         aw_held_r <= aw_have && !wr_fire;
         w_held_r <= w_have && !wr_fire;
         if (wr_fire) begin
            o_bvalid <= 1'b1;
            o_bresp <= wa_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (i_bready) begin
            o_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         enable_r <= 1'b0;
         slot_div_r <= SLOT_REF_CLKS_16;
         padsel_r <= PADSEL_RST;
         mode_r <= 24'h000000;
         batt_thr_r <= BATT_THR_RST;
      end else if (wr_fire) begin
         if (wa == OFF_CTRL) begin
            enable_r <= ctrl_new[0];
            slot_div_r <= (ctrl_new[16:1] == 16'h0000) ? 16'h0001 : ctrl_new[16:1];
         end
         if (wa == OFF_PADSEL) padsel_r <= pad_new[5:0];
         if (wa == OFF_MODE) mode_r <= mode_new[23:0];
         if (wa == OFF_BATT_THR) batt_thr_r <= thr_new[9:0];
      end
   end

   // Limit pairs reset to the full native range: min -512, max +511.
   generate
      for (genvar g = 0; g < NUM_CH; g++) begin : g_lim
         always_ff @(posedge i_clk) begin
            if (i_rst) begin
               limit_r[g] <= {10'h1ff, 10'h200};
            end else if (wr_fire && wa_limit && wa_idx == 3'(g)) begin
               limit_r[g] <= lim_new[19:0];
            end
         end
      end
   endgenerate

   // A new low reading in the same cycle as a software clear wins, so no event is lost.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         batt_cnt_r <= 16'h0000;
         sample_err_r <= 1'b0;
      end else begin
         if (batt_hit) begin
            batt_cnt_r <= cnt_clear ? 16'h0001 :
                          ((batt_cnt_r == 16'hffff) ? batt_cnt_r : batt_cnt_r + 16'h0001);
         end else if (cnt_clear) begin
            batt_cnt_r <= 16'h0000;
         end
         if (enable_r && tick_due && state_r != ST_IDLE) begin
            sample_err_r <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // AXI4-Lite read path
   // ---------------------------------------------------------------
   wire ra_res = (i_araddr >= OFF_RESULT0) && (i_araddr < OFF_RESULT0 + 8'h20) &&
                 (i_araddr[1:0] == 2'h0);
   wire ra_lim = (i_araddr >= OFF_LIMIT0) && (i_araddr < OFF_LIMIT0 + 8'h20) &&
                 (i_araddr[1:0] == 2'h0);
   wire [2:0] ra_idx = i_araddr[4:2];
   wire [31:0] status_word = {27'h0, sample_err_r, ch_r, state_r == ST_CONV};
   wire [31:0] rd_word =
      (i_araddr == OFF_CTRL) ? ctrl_old :
      (i_araddr == OFF_PADSEL) ? {26'h0, padsel_r} :
      (i_araddr == OFF_MODE) ? {8'h00, mode_r} :
      (i_araddr == OFF_BATT_THR) ? {22'h0, batt_thr_r} :
      (i_araddr == OFF_BATT_CNT) ? {16'h0000, batt_cnt_r} :
      (i_araddr == OFF_STATUS) ? status_word :
      (i_araddr == OFF_ID) ? ID_VALUE :
      ra_res ? {{22{result_r[ra_idx][9]}}, result_r[ra_idx]} :
      ra_lim ? {12'h000, limit_r[ra_idx]} : 32'h0000_0000;
   wire rd_ok = (i_araddr == OFF_CTRL) || (i_araddr == OFF_PADSEL) || (i_araddr == OFF_MODE) ||
                (i_araddr == OFF_BATT_THR) || (i_araddr == OFF_BATT_CNT) ||
                (i_araddr == OFF_STATUS) || (i_araddr == OFF_ID) || ra_res || ra_lim;

   assign o_arready = !o_rvalid;
   wire ar_take = i_arvalid && o_arready;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_rvalid <= 1'b0;
         o_rdata <= 32'h0000_0000;
         o_rresp <= RESP_OKAY;
      end else if (ar_take) begin
         o_rvalid <= 1'b1;
         o_rdata <= rd_word;
         o_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (i_rready) begin
         o_rvalid <= 1'b0;
      end
   end

endmodule : low_speed_adc

// ### verification/adc_checker.sv
// Checker with concurrent assertions on the ports of the low speed adc block.
`timescale 1ns/100ps
module adc_checker (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_bready,
   input wire logic [1:0] o_bresp,
   input wire logic o_bvalid,
   input wire logic o_awready,
   input wire logic i_arvalid,
   input wire logic o_arready,
   input wire logic [31:0] o_rdata,
   input wire logic [1:0] o_rresp,
   input wire logic o_rvalid,
   input wire logic i_rready,
   input wire logic [2:0] o_mux_sel,
   input wire logic o_conv_start,
   input wire logic i_conv_done
);
   import adc_mon_pkg::*;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // ------------------------------------------------------------
   // Channel sequencing
   // ------------------------------------------------------------
   // The finished channel is kept so the step after the store can be checked.
   logic [2:0] done_ch_r;
   always_ff @(posedge i_clk) begin
      if (i_conv_done) begin
         done_ch_r <= o_mux_sel;
      end
   end
   mux_step_a: assert property (
      !$past(i_rst) && $changed(o_mux_sel) |-> o_mux_sel == 3'($past(o_mux_sel) + 3'h1))
      else $error("Channel select did not step by one.");
   done_step_a: assert property (
      i_conv_done |=> ##[0:2] o_mux_sel == 3'(done_ch_r + 3'h1))
      else $error("Channel select did not advance after a conversion.");
   start_hold_a: assert property (o_conv_start |=> $stable(o_mux_sel))
      else $error("Channel select moved during a conversion.");
   start_gap_a: assert property (o_conv_start |=> !o_conv_start [*2])
      else $error("Conversion restarted before the previous one ended.");
   // ------------------------------------------------------------
   // Register bus
   // ------------------------------------------------------------
   bresp_hold_a: assert property (
      o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
      else $error("Write response dropped before it was taken.");
   rdata_hold_a: assert property (
      o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("Read data changed before it was taken.");
   aw_block_a: assert property (o_bvalid |-> !o_awready)
      else $error("Write address accepted with a response pending.");
   read_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid && !o_arready)
      else $error("Read address taken without an answer next cycle.");
   err_zero_a: assert property (o_rvalid && o_rresp == RESP_SLVERR |-> o_rdata == 32'h0)
      else $error("Refused read returned nonzero data.");
endmodule : adc_checker

bind low_speed_adc adc_checker adc_checker_i (.i_clk, .i_rst, .i_bready, .o_bresp, .o_bvalid,
   .o_awready, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .o_mux_sel,
   .o_conv_start, .i_conv_done);

// ### verification/low_speed_adc_test.sv
// Self-checking testbench for the low speed adc block through its AXI4-Lite registers.
`timescale 1ns/100ps
module low_speed_adc_test;
   import adc_mon_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
   logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
   logic [31:0] i_wdata = 32'h0;
   logic [3:0] i_wstrb = 4'hf;
   logic i_conv_done = 1'b0;
   logic [RES_W-1:0] i_conv_data = 10'h000;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_conv_start;
   logic [1:0] o_bresp, o_rresp;
   logic [31:0] o_rdata;
   logic [2:0] o_mux_sel;
   logic [5:0] o_pad_adc_sel;
   logic [2:0] pend_r = 3'h0;
   logic [9:0] vals [8] = '{10'h1f0, 10'h3f0, 10'h200, 10'h1ff, 10'h005, 10'h3ff, 10'h050, 10'h000};
   int errors = 0, check_count = 0, sup_hits = 0;
   always #4 i_clk = ~i_clk;
   low_speed_adc low_speed_adc_i (.i_clk, .i_rst, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
      .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
      .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .o_mux_sel, .o_conv_start,
      .i_conv_done, .i_conv_data, .o_pad_adc_sel);
   // ------------------------------------------------------------
   // Converter stand-in and bus tasks
   // ------------------------------------------------------------
   // A fixed answer delay keeps the sequencer busy long enough to expose early restarts.
   always @(posedge i_clk) begin
      pend_r <= {pend_r[1:0], o_conv_start};
      i_conv_done <= pend_r[2];
      i_conv_data <= vals[o_mux_sel];
      if (i_conv_done === 1'b1 && o_mux_sel === CH_SUPPLY) sup_hits <= sup_hits + 1;
   end
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rsp);
      @(posedge i_clk);
      i_awaddr <= a;
      i_wdata <= d;
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      i_bready <= 1'b1;
      do begin
         @(posedge i_clk);
         if (o_awready === 1'b1) i_awvalid <= 1'b0;
         if (o_wready === 1'b1) i_wvalid <= 1'b0;
      end while (o_bvalid !== 1'b1);
      i_bready <= 1'b0;
      chk("bresp", {30'h0, rsp}, {30'h0, o_bresp});
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] rsp);
      @(posedge i_clk);
      i_araddr <= a;
      i_arvalid <= 1'b1;
      i_rready <= 1'b1;
      do begin
         @(posedge i_clk);
         if (o_arready === 1'b1) i_arvalid <= 1'b0;
      end while (o_rvalid !== 1'b1);
      i_rready <= 1'b0;
      chk($sformatf("read %h", a), exp, o_rdata);
      chk("rresp", {30'h0, rsp}, {30'h0, o_rresp});
   endtask : rd
   // Limit pair m spans plus and minus (40m + 20); channel n runs in mode n.
   function automatic logic [31:0] lim(input int n);
      int v;
      v = $signed(vals[n]);
      if (v < -(n * 40 + 20)) v = -(n * 40 + 20);
      if (v > n * 40 + 20) v = n * 40 + 20;
      return 32'(v);
   endfunction : lim
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : close_out
   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      repeat (20) @(posedge i_clk);
      i_rst <= 1'b0;
      rd(OFF_CTRL, 32'h0000_00c8, RESP_OKAY);
      rd(OFF_BATT_CNT, 32'h0, RESP_OKAY);
      rd(OFF_LIMIT0, 32'h0007_fe00, RESP_OKAY);
      rd(OFF_ID, ID_VALUE, RESP_OKAY);
      rd(8'hfc, 32'h0, RESP_SLVERR);
      wr(8'hfc, 32'h1, RESP_SLVERR);
      $display("test reset values done");
      wr(OFF_PADSEL, 32'h2a, RESP_OKAY);
      chk("pad select", 32'h2a, {26'h0, o_pad_adc_sel});
      rd(OFF_PADSEL, 32'h2a, RESP_OKAY);
      $display("test pad select done");
      wr(OFF_BATT_THR, 32'h100, RESP_OKAY);
      for (int m = 0; m < 8; m++) begin
         wr(OFF_LIMIT0 + 8'(4 * m), {12'h0, 10'(m * 40 + 20), 10'(-(m * 40 + 20))}, RESP_OKAY);
      end
      wr(OFF_MODE, 32'h00fa_c688, RESP_OKAY);
      wr(OFF_CTRL, 32'h11, RESP_OKAY);
      while (sup_hits < 2) @(posedge i_clk);
      wr(OFF_CTRL, 32'h10, RESP_OKAY);
      repeat (20) @(posedge i_clk);
      for (int n = 0; n < 8; n++) begin
         rd(OFF_RESULT0 + 8'(4 * n), lim(n), RESP_OKAY);
      end
      rd(OFF_STATUS, 32'h0000_000e, RESP_OKAY);
      rd(OFF_BATT_CNT, 32'(sup_hits), RESP_OKAY);
      wr(OFF_BATT_CNT, 32'h0, RESP_OKAY);
      rd(OFF_BATT_CNT, 32'h0, RESP_OKAY);
      $display("test conversion sweep done");
      // A supply reading at or above the threshold must leave the counter alone.
      wr(OFF_BATT_THR, 32'h40, RESP_OKAY);
      wr(OFF_CTRL, 32'h11, RESP_OKAY);
      while (sup_hits < 3) @(posedge i_clk);
      wr(OFF_CTRL, 32'h10, RESP_OKAY);
      repeat (20) @(posedge i_clk);
      rd(OFF_BATT_CNT, 32'h0, RESP_OKAY);
      rd(OFF_RESULT0 + 8'h18, lim(6), RESP_OKAY);
      $display("test threshold done");
      close_out();
   end
   initial begin
      repeat (20000) @(posedge i_clk);
      errors++;
      close_out();
   end
endmodule : low_speed_adc_test
